// >>> bcdtk_pkg.sv
package bcdtk_pkg;

    typedef struct packed {
        logic [7:0] yr;
        logic [7:0] mon;
        logic [7:0] day;
        logic [7:0] wday;
        logic [7:0] hr;
        logic [7:0] min;
        logic [7:0] sec;
    } bcdtk_time_t;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_HALF = 2'b01,
        KEY_OPEN = 2'b10
    } bcdtk_key_t;

    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_KEY = 8'h04;
    localparam logic [7:0] OFS_VALH = 8'h08;
    localparam logic [7:0] OFS_VALL = 8'h0C;
    localparam logic [7:0] OFS_ALCFG = 8'h10;
    localparam logic [7:0] OFS_ALH = 8'h14;
    localparam logic [7:0] OFS_ALL = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1C;

    localparam int CFG_EN_BIT = 7;
    localparam int CFG_WREN_BIT = 5;
    localparam int CFG_SYNC_BIT = 4;
    localparam int STAT_HALF_BIT = 0;
    localparam logic [1:0] PTR_MIN_SEC = 2'b00;
    localparam logic [1:0] PTR_WDHR = 2'b01;
    localparam logic [1:0] PTR_MONDAY = 2'b10;
    localparam logic [1:0] PTR_RST = 2'b00;

    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    localparam logic [7:0] MASK_HR = 8'h3F;
    localparam logic [7:0] MASK_MS = 8'h7F;
    localparam logic [7:0] MASK_WD = 8'h07;
    localparam logic [7:0] MASK_DAY = 8'h3F;
    localparam logic [7:0] MASK_MON = 8'h1F;

    localparam logic [7:0] LAST_MS = 8'h59;
    localparam logic [7:0] LAST_HR = 8'h23;
    localparam logic [7:0] LAST_WD = 8'h06;
    localparam logic [7:0] LAST_MON = 8'h12;
    localparam logic [7:0] LAST_YR = 8'h99;
    localparam logic [7:0] FIRST_DM = 8'h01;

    localparam bcdtk_time_t RST_TIME = '{8'h00, 8'h01, 8'h01, 8'h06,
                                        8'h00, 8'h00, 8'h00};

    localparam int XTAL_HZ = 32768;
    localparam int HALF_SEC_MS = 500;
    localparam int HALF_SEC_TICKS = XTAL_HZ * HALF_SEC_MS / 1000;
    localparam int SYNC_LEAD_TICKS = 32;

    // Decimal carry at ten, not sixteen [RL12] [RL6]
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction

    // Range 2000..2099 only, so divisible by four is enough [RL14]
    function automatic logic is_leap(input logic [7:0] y);
        if (y[4]) begin
            return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    endfunction

    // Last day of month [RL13]
    function automatic logic [7:0] month_last(input logic [7:0] m,
                                              input logic [7:0] y);
        if (m == 8'h02) begin
            return is_leap(y) ? 8'h29 : 8'h28;
        end
        if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
            return 8'h30;
        end
        return 8'h31;
    endfunction

endpackage

// >>> bcdtk_time_if.sv
`timescale 1ns/1ns
interface bcdtk_time_if;
    bcdtk_pkg::bcdtk_time_t cur;
    bcdtk_pkg::bcdtk_time_t nxt;
    modport core (input cur, output nxt);
    modport keeper (output cur, input nxt);
endinterface

// >>> bcdtk_calendar.sv
`timescale 1ns/1ns
module bcdtk_calendar import bcdtk_pkg::*; (
    bcdtk_time_if.core t
);
    bcdtk_time_t n;

    always_comb begin
        n = t.cur;
        n.sec = bcd_inc(t.cur.sec);
        if (t.cur.sec == LAST_MS) begin
            n.sec = 8'h00;
            n.min = bcd_inc(t.cur.min);
            if (t.cur.min == LAST_MS) begin
                n.min = 8'h00;
                n.hr = bcd_inc(t.cur.hr);
                if (t.cur.hr == LAST_HR) begin // [RL8]
                    n.hr = 8'h00;
                    // Weekday wraps alone [RL10]
                    n.wday = (t.cur.wday == LAST_WD) ? 8'h00
                                                     : bcd_inc(t.cur.wday);
                    n.day = bcd_inc(t.cur.day);
                    if (t.cur.day == month_last(t.cur.mon, t.cur.yr)) begin
                        n.day = FIRST_DM; // [RL13]
                        n.mon = bcd_inc(t.cur.mon);
                        if (t.cur.mon == LAST_MON) begin // [RL9]
                            n.mon = FIRST_DM;
                            n.yr = (t.cur.yr == LAST_YR) ? 8'h00
                                                         : bcd_inc(t.cur.yr);
                        end // [RL11]
                    end
                end
            end
        end
    end

    assign t.nxt = n;
endmodule

// >>> bcdtk_prescaler.sv
`timescale 1ns/1ns
module bcdtk_prescaler #(
    parameter int HALF_TICKS = 16384,
    parameter int LEAD = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic clr_cnt_i,
    input wire logic clr_half_i,
    output logic half_o,
    output logic sec_pulse_o,
    output logic sync_o
);
    localparam int W = $clog2(HALF_TICKS);
    localparam logic [W-1:0] CNT_LAST = W'(HALF_TICKS - 1);
    localparam logic [W-1:0] CNT_SYNC = W'(HALF_TICKS - LEAD);

    // Lead of one would raise sync only in the step cycle itself
    if (HALF_TICKS < 4 || LEAD < 2 || LEAD >= HALF_TICKS) begin : g_chk
        $error("bcdtk_prescaler: bad HALF_TICKS or LEAD");
    end

    logic [W-1:0] cnt_reg;
    logic half_reg;
    logic wrap;

    assign wrap = run_i && tick_i && (cnt_reg == CNT_LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i || clr_cnt_i) begin // [RL17]
            cnt_reg <= '0;
        end else if (run_i && tick_i) begin
            cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
        end
    end

    // Half-second bit only cleared by a seconds write [RL19]
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_half_i) begin
            half_reg <= 1'b0;
        end else if (wrap) begin
            half_reg <= ~half_reg;
        end
    end

    assign half_o = half_reg;
    assign sec_pulse_o = wrap && half_reg && !clr_cnt_i;
    // Raised LEAD ticks early, dropped after the step [RL24] [RL20]
    assign sync_o = run_i && half_reg && (cnt_reg >= CNT_SYNC);

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sync_before_step_a: assert property ( // [RL24]
        sec_pulse_o |-> $past(sync_o) && sync_o)
        else $error("step without leading sync");
    prescale_clear_a: assert property ( // [RL17]
        clr_cnt_i |=> cnt_reg == '0)
        else $error("prescaler not cleared by write");
endmodule

// >>> bcdtk_timekeeper.sv
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ns
// Function
// [RL1] Alarm hour: tens in bits 5:4, ones in 3:0, bits 7:6 zero.
// [RL2] Alarm hour writes land only while write unlock is set.
// [RL3] Alarm minute/second: tens in bits 6:4, ones 3:0, bit 7 zero.
// [RL4] Enable bit ignores writes while write unlock is clear.
// [RL5] Value window writes dropped while write unlock is clear.
// [RL6] Every time and alarm digit is BCD in its own nibble.
// [RL7] Fuse picks crystal ticks or internal RC ticks as timebase.
// [RL8] Time 23:59:59 rolls to 00:00:00 and advances the day.
// [RL9] Date 12/31 rolls to 01/01 and advances the year.
// [RL10] Weekday wraps 6 to 0 without any further carry.
// [RL11] Year wraps 99 to 00 with no further carry.
// [RL12] BCD ones digits carry into tens at ten.
// [RL13] Day wraps to 01 after 30, 31, 28 or 29 by month.
// [RL14] Years divisible by four give February 29 days.
// [RL15] Counting continues from newly written values while enabled.
// [RL16] Timekeeper runs only while config bit 7 is set.
// [RL17] Minute/second writes clear both prescalers; minute writes here clear only the tick counter, not the half-second bit.
// [RL18] Writes land at once; software avoids colliding increments.
// [RL19] Half-second bit read-only, cleared only by seconds write.
// [RL20] Sync flag reads 0 while access is rollover safe.
// [RL21] Software reads each register twice and compares.
// [RL22] Unlock bit settable only right after 55h then AAh.
// [RL23] High window access decrements pointer until 00.
// [RL24] Sync flag rises before an increment, holds until done.
module bcdtk_timekeeper import bcdtk_pkg::*; #(
    parameter int HALF_TICKS = HALF_SEC_TICKS,
    parameter int SYNC_LEAD = SYNC_LEAD_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic timebase_select_fuse_i,
    input wire logic xtal_tick_i,
    input wire logic rc_tick_i
);
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [31:0] rdata;
    logic fire;
    logic wr;
    logic [7:0] wd;

    logic timekeeper_enable_reg;
    logic write_unlock_bit_reg;
    logic [1:0] value_pointer_reg;
    logic [1:0] alarm_pointer_reg;
    bcdtk_key_t key_reg;

    bcdtk_time_t time_reg;
    bcdtk_time_t time_next;
    logic [7:0] alarm_hour_value_reg;
    logic [7:0] alarm_minute_value_reg;
    logic [7:0] alarm_second_value_reg;

    logic tick;
    logic step;
    logic half_sec;
    logic rollover_safe_flag;
    logic min_sec_wr;
    logic sec_wr;
    logic unlocked_wr;

    bcdtk_time_if tif ();

    // Classic Wishbone: one wait state, ack for one cycle
    assign fire = cyc_i && stb_i && ack_reg;
    assign wr = fire && we_i && sel_i[0];
    assign wd = dat_i[7:0];
    assign unlocked_wr = wr && write_unlock_bit_reg;
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= cyc_i && stb_i && !ack_reg;
        end
    end

    function automatic logic [7:0] win_hi(input logic [1:0] p,
                                          input bcdtk_time_t t);
        unique case (p)
            PTR_MIN_SEC: return t.min;
            PTR_WDHR: return t.wday;
            PTR_MONDAY: return t.mon;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] win_lo(input logic [1:0] p,
                                          input bcdtk_time_t t);
        unique case (p)
            PTR_MIN_SEC: return t.sec;
            PTR_WDHR: return t.hr;
            PTR_MONDAY: return t.day;
            default: return t.yr;
        endcase
    endfunction

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (adr_i)
            OFS_CFG: begin
                rdata[CFG_EN_BIT] = timekeeper_enable_reg;
                rdata[CFG_WREN_BIT] = write_unlock_bit_reg;
                rdata[CFG_SYNC_BIT] = rollover_safe_flag; // [RL20]
                rdata[1:0] = value_pointer_reg;
            end
            OFS_VALH: rdata[7:0] = win_hi(value_pointer_reg, time_reg);
            OFS_VALL: rdata[7:0] = win_lo(value_pointer_reg, time_reg);
            OFS_ALCFG: rdata[1:0] = alarm_pointer_reg;
            OFS_ALH: begin
                if (alarm_pointer_reg == PTR_MIN_SEC) begin
                    rdata[7:0] = alarm_minute_value_reg; // [RL3]
                end
            end
            OFS_ALL: begin
                if (alarm_pointer_reg == PTR_MIN_SEC) begin
                    rdata[7:0] = alarm_second_value_reg; // [RL3]
                end else if (alarm_pointer_reg == PTR_WDHR) begin
                    rdata[7:0] = alarm_hour_value_reg; // [RL1]
                end
            end
            OFS_STAT: rdata[STAT_HALF_BIT] = half_sec; // [RL19]
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Captured in the request cycle so the pointer seen is pre-decrement
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (cyc_i && stb_i && !ack_reg) begin
            dat_reg <= rdata;
        end
    end

    // Unlock key: next bus access after AAh is the only chance
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_reg <= KEY_IDLE;
        end else if (fire) begin
            unique case (key_reg)
                KEY_IDLE, KEY_OPEN: begin
                    key_reg <= (wr && adr_i == OFS_KEY && wd == KEY_FIRST)
                               ? KEY_HALF : KEY_IDLE;
                end
                KEY_HALF: begin
                    key_reg <= (wr && adr_i == OFS_KEY && wd == KEY_SECOND)
                               ? KEY_OPEN : KEY_IDLE; // [RL22]
                end
                default: key_reg <= KEY_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            write_unlock_bit_reg <= 1'b0;
        end else if (wr && adr_i == OFS_CFG) begin
            if (!wd[CFG_WREN_BIT]) begin
                write_unlock_bit_reg <= 1'b0;
            end else if (key_reg == KEY_OPEN) begin
                write_unlock_bit_reg <= 1'b1; // [RL22]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timekeeper_enable_reg <= 1'b0;
        end else if (unlocked_wr && adr_i == OFS_CFG) begin
            timekeeper_enable_reg <= wd[CFG_EN_BIT]; // [RL4]
        end
    end

    // Pointers step down on any high-window access, stop at 00
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            value_pointer_reg <= PTR_RST;
        end else if (wr && adr_i == OFS_CFG) begin
            value_pointer_reg <= wd[1:0];
        end else if (fire && adr_i == OFS_VALH
                     && value_pointer_reg != 2'b00) begin
            value_pointer_reg <= value_pointer_reg - 2'b01; // [RL23]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_pointer_reg <= PTR_RST;
        end else if (wr && adr_i == OFS_ALCFG) begin
            alarm_pointer_reg <= wd[1:0];
        end else if (fire && adr_i == OFS_ALH
                     && alarm_pointer_reg != 2'b00) begin
            alarm_pointer_reg <= alarm_pointer_reg - 2'b01;
        end
    end

    // Alarm registers keep unused high bits at zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_hour_value_reg <= 8'h00;
        end else if (unlocked_wr && adr_i == OFS_ALL
                     && alarm_pointer_reg == PTR_WDHR) begin
            alarm_hour_value_reg <= wd & MASK_HR; // [RL1] [RL2]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_minute_value_reg <= 8'h00;
            alarm_second_value_reg <= 8'h00;
        end else if (unlocked_wr && alarm_pointer_reg == PTR_MIN_SEC) begin
            if (adr_i == OFS_ALH) begin
                alarm_minute_value_reg <= wd & MASK_MS; // [RL3]
            end
            if (adr_i == OFS_ALL) begin
                alarm_second_value_reg <= wd & MASK_MS; // [RL3]
            end
        end
    end

    // Timebase mux; fuse 1 selects crystal [RL7]
    assign tick = timebase_select_fuse_i ? xtal_tick_i : rc_tick_i;

    assign min_sec_wr = unlocked_wr && value_pointer_reg == PTR_MIN_SEC
                       && (adr_i == OFS_VALH || adr_i == OFS_VALL);
    assign sec_wr = min_sec_wr && adr_i == OFS_VALL;

    bcdtk_prescaler #(
        .HALF_TICKS(HALF_TICKS),
        .LEAD(SYNC_LEAD)
    ) u_pre (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .run_i(timekeeper_enable_reg), // [RL16]
        .clr_cnt_i(min_sec_wr), // [RL17]
        .clr_half_i(sec_wr), // [RL19]
        .half_o(half_sec),
        .sec_pulse_o(step),
        .sync_o(rollover_safe_flag)
    );

    assign tif.cur = time_reg;

    bcdtk_calendar u_cal (
        .t(tif.core)
    );

    // Step first, then the write overrides its own field [RL18] [RL15]
    always_comb begin
        time_next = step ? tif.nxt : time_reg;
        if (unlocked_wr && adr_i == OFS_VALH) begin // [RL5]
            unique case (value_pointer_reg)
                PTR_MIN_SEC: time_next.min = wd & MASK_MS;
                PTR_WDHR: time_next.wday = wd & MASK_WD;
                PTR_MONDAY: time_next.mon = wd & MASK_MON;
                default: time_next.yr = time_next.yr;
            endcase
        end
        if (unlocked_wr && adr_i == OFS_VALL) begin // [RL5]
            unique case (value_pointer_reg)
                PTR_MIN_SEC: time_next.sec = wd & MASK_MS;
                PTR_WDHR: time_next.hr = wd & MASK_HR;
                PTR_MONDAY: time_next.day = wd & MASK_DAY;
                default: time_next.yr = wd;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            time_reg <= RST_TIME;
        end else begin
            time_reg <= time_next;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_midnight;
        step && time_reg.hr == LAST_HR && time_reg.min == LAST_MS
            && time_reg.sec == LAST_MS && !wr;
    endsequence

    sequence s_year_end;
        s_midnight ##0 time_reg.mon == LAST_MON && time_reg.day == 8'h31;
    endsequence

    sequence s_to_midnight;
        time_reg.hr == 8'h00 && time_reg.min == 8'h00
            && time_reg.sec == 8'h00;
    endsequence

    alarm_hour_a: assert property ( // [RL1]
        unlocked_wr && adr_i == OFS_ALL && alarm_pointer_reg == PTR_WDHR
        |=> ({24'h0, alarm_hour_value_reg} == ($past(dat_i) & 32'h3F)))
        else $error("alarm hour not written with mask");
    alarm_lock_a: assert property ( // [RL2]
        wr && !write_unlock_bit_reg && adr_i == OFS_ALL
        |=> $stable(alarm_hour_value_reg))
        else $error("locked alarm hour write landed");
    alarm_minute_a: assert property ( // [RL3]
        unlocked_wr && adr_i == OFS_ALH && alarm_pointer_reg == PTR_MIN_SEC
        |=> ({24'h0, alarm_minute_value_reg} == ($past(dat_i) & 32'h7F)))
        else $error("alarm minute not written with mask");
    enable_lock_a: assert property ( // [RL4]
        wr && adr_i == OFS_CFG && !write_unlock_bit_reg
        |=> $stable(timekeeper_enable_reg))
        else $error("enable changed while locked");
    window_lock_a: assert property ( // [RL5]
        wr && !write_unlock_bit_reg && !step
        && (adr_i == OFS_VALH || adr_i == OFS_VALL)
        |=> $stable(time_reg))
        else $error("locked window write landed");
    midnight_roll_a: assert property ( // [RL8]
        s_midnight |=> s_to_midnight
            and (time_reg.day != $past(time_reg.day)))
        else $error("midnight rollover wrong");
    year_roll_a: assert property ( // [RL9]
        s_year_end |=> time_reg.mon == FIRST_DM && time_reg.day == FIRST_DM
            && time_reg.yr != $past(time_reg.yr))
        else $error("year rollover wrong");
    run_gate_a: assert property ( // [RL16]
        !timekeeper_enable_reg && !wr |=> $stable(time_reg))
        else $error("time moved while disabled");
    pointer_step_a: assert property ( // [RL23]
        fire && adr_i == OFS_VALH && value_pointer_reg != 2'b00
        |=> value_pointer_reg == $past(value_pointer_reg) - 2'b01)
        else $error("pointer did not step down");
    unlock_window_a: assert property ( // [RL22]
        $rose(write_unlock_bit_reg) |-> $past(key_reg) == KEY_OPEN)
        else $error("unlock set outside key window");
    ack_pulse_a: assert property (
        cyc_i && stb_i && !ack_reg |=> ack_o ##1 !ack_o)
        else $error("ack not a single pulse");
endmodule

// >>> bcdtk_timekeeper_test.sv
`timescale 1ns/1ns
module bcdtk_timekeeper_test import bcdtk_pkg::*;;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic fuse = 1, xt = 0, rc = 0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_o;
    logic ack_o;
    int bad_count = 0, samples_checked = 0;
    // Rows: year, month, day, then expected year, month, day
    logic [7:0] tb [6][6] = '{'{8'h99, 8'h12, 8'h31, 8'h00, 8'h01, 8'h01},
        '{8'h04, 8'h02, 8'h28, 8'h04, 8'h02, 8'h29},
        '{8'h01, 8'h02, 8'h28, 8'h01, 8'h03, 8'h01},
        '{8'h00, 8'h04, 8'h30, 8'h00, 8'h05, 8'h01},
        '{8'h00, 8'h01, 8'h31, 8'h00, 8'h02, 8'h01},
        '{8'h00, 8'h09, 8'h29, 8'h00, 8'h09, 8'h30}};

    bcdtk_timekeeper #(.HALF_TICKS(8), .SYNC_LEAD(2)) u_bcdtk_timekeeper (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
        .dat_o(dat_o), .ack_o(ack_o), .timebase_select_fuse_i(fuse),
        .xtal_tick_i(xt), .rc_tick_i(rc));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Single classic cycle; no cycle count assumed for the answer
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        sel_i <= 4'hF;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
        end
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                       input string nm);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(nm, e, q);
        chk({nm, " upper"}, 8'h00, {7'h0, |dat_o[31:8]});
    endtask

    task automatic run(input int n, input logic f, input logic x,
                       input logic r);
        @(posedge clk_i);
        fuse <= f;
        xt <= x;
        rc <= r;
        repeat (n) @(posedge clk_i);
        xt <= 1'b0;
        rc <= 1'b0;
    endtask

    task automatic unlock(input logic [7:0] cfg);
        wr(OFS_KEY, KEY_FIRST);
        wr(OFS_KEY, KEY_SECOND);
        wr(OFS_CFG, cfg);
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        results();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(OFS_CFG, 8'h00, "cfg reset");
        wr(OFS_CFG, 8'h80);
        rdc(OFS_CFG, 8'h00, "locked enable");
        wr(OFS_VALL, 8'h12);
        rdc(OFS_VALL, 8'h00, "locked window");
        wr(OFS_ALCFG, 8'h01);
        wr(OFS_ALL, 8'h12);
        rdc(OFS_ALL, 8'h00, "locked alarm hour");
        rdc(8'h20, 8'h00, "unmapped");
        wr(OFS_KEY, KEY_FIRST);
        wr(OFS_KEY, KEY_SECOND);
        rdc(OFS_STAT, 8'h00, "stat between");
        wr(OFS_CFG, 8'h20);
        rdc(OFS_CFG, 8'h00, "late unlock");
        unlock(8'h20);
        rdc(OFS_CFG, 8'h20, "unlock set");
        $display("test locks done");
        wr(OFS_ALCFG, 8'h01);
        wr(OFS_ALL, 8'hE3);
        rdc(OFS_ALL, 8'h23, "alarm hour");
        wr(OFS_ALCFG, 8'h00);
        wr(OFS_ALL, 8'hD9);
        rdc(OFS_ALL, 8'h59, "alarm second");
        wr(OFS_ALH, 8'hC5);
        rdc(OFS_ALH, 8'h45, "alarm minute");
        $display("test alarms done");
        foreach (tb[i]) begin
            wr(OFS_CFG, 8'h23);
            wr(OFS_VALL, tb[i][0]);
            wr(OFS_VALH, 8'h00);
            wr(OFS_VALL, tb[i][2]);
            wr(OFS_VALH, tb[i][1]);
            wr(OFS_VALL, 8'h23);
            wr(OFS_VALH, 8'h06);
            wr(OFS_VALL, 8'h59);
            wr(OFS_VALH, 8'h59);
            wr(OFS_CFG, 8'hA0);
            run(20, 1'b1, 1'b1, 1'b0);
            wr(OFS_CFG, 8'hA3);
            rdc(OFS_VALL, tb[i][3], "year");
            rdc(OFS_VALH, 8'h00, "empty slot");
            rdc(OFS_VALL, tb[i][5], "day");
            rdc(OFS_VALH, tb[i][4], "month");
            rdc(OFS_VALL, 8'h00, "hour");
            rdc(OFS_VALH, 8'h00, "weekday");
            rdc(OFS_VALL, 8'h00, "second");
            rdc(OFS_VALH, 8'h00, "minute");
        end
        $display("test calendar done");
        wr(OFS_VALL, 8'h00);
        run(20, 1'b0, 1'b1, 1'b0);
        rdc(OFS_VALL, 8'h00, "crystal unselected");
        run(20, 1'b0, 1'b0, 1'b1);
        rdc(OFS_VALL, 8'h01, "rc selected");
        rdc(OFS_VALL, 8'h01, "second reread");
        wr(OFS_CFG, 8'h20);
        run(40, 1'b0, 1'b0, 1'b1);
        rdc(OFS_VALL, 8'h01, "disabled");
        wr(OFS_CFG, 8'hA0);
        run(10, 1'b0, 1'b0, 1'b1);
        rdc(OFS_STAT, 8'h01, "half set");
        rdc(OFS_CFG, 8'hB0, "sync raised");
        wr(OFS_STAT, 8'h00);
        wr(OFS_VALH, 8'h00);
        rdc(OFS_STAT, 8'h01, "half kept");
        wr(OFS_VALL, 8'h00);
        rdc(OFS_STAT, 8'h00, "half cleared");
        $display("test timebase done");
        results();
    end
endmodule
